/* lcd_core_pkg.sv */
// Shared constants, configuration layout and state codes of the segment LCD display core
package lcd_core_pkg;

  // ****************************************************************
  // Clocks and derived timing
  // ****************************************************************
  localparam int MCLK_HZ       = 40_000_000;
  localparam int SYS_HZ        = 32_000;
  localparam int SYS_DIV       = MCLK_HZ / SYS_HZ;
  localparam int FRAME_SLOW_HZ = 80;
  localparam int FRAME_FAST_HZ = 160;
  localparam int DUTY_FOUR     = 4;
  localparam int DUTY_EIGHT    = 8;
  localparam int SLOT_SLOW_4   = SYS_HZ / (FRAME_SLOW_HZ * DUTY_FOUR);
  localparam int SLOT_SLOW_8   = SYS_HZ / (FRAME_SLOW_HZ * DUTY_EIGHT);
  localparam int SLOT_FAST_4   = SYS_HZ / (FRAME_FAST_HZ * DUTY_FOUR);
  localparam int SLOT_FAST_8   = SYS_HZ / (FRAME_FAST_HZ * DUTY_EIGHT);
  localparam int BLINK_DIV1    = 16384;
  localparam int BLINK_DIV2    = 32768;
  localparam int BLINK_DIV3    = 65536;
  localparam int BLINK_BIT1    = $clog2(BLINK_DIV1) - 1;
  localparam int BLINK_BIT2    = $clog2(BLINK_DIV2) - 1;
  localparam int BLINK_BIT3    = $clog2(BLINK_DIV3) - 1;
  localparam int POR_QUIET_MS  = 1;

  // ****************************************************************
  // Serial slave and display memory
  // ****************************************************************
  localparam logic [6:0] DEV_ADDR    = 7'h38;
  localparam int         RAM_WORDS   = 16;
  localparam logic [3:0] BITS_BYTE   = 4'h8;

  // ****************************************************************
  // Drive levels, in steps of one bias fraction of the LCD supply
  // ****************************************************************
  typedef logic [2:0] lvl_t;
  localparam lvl_t LVL_SEG_ON  = 3'h0;
  localparam lvl_t LVL_NONSEL  = 3'h1;
  localparam lvl_t LVL_SEG_OFF = 3'h2;
  localparam lvl_t LVL_FULL_3  = 3'h3;
  localparam lvl_t LVL_FULL_4  = 3'h4;

  // ****************************************************************
  // Configuration word
  // ****************************************************************
  typedef struct packed {
    logic       osc_on;
    logic       bias_on;
    logic       display_on;
    logic       duty_eighth;
    logic       bias_quarter;
    logic       frame_fast;
    logic [1:0] blink_mode;
    logic       vadj_enable;
    logic [3:0] voltage_trim_code;
    logic       shared_pin_supply;
    logic       supply_detect_on;
  } lcd_cfg_t;

  localparam lcd_cfg_t CFG_RESET = '{
    osc_on:            1'b0,
    bias_on:           1'b0,
    display_on:        1'b0,
    duty_eighth:       1'b0,
    bias_quarter:      1'b0,
    frame_fast:        1'b0,
    blink_mode:        2'h0,
    vadj_enable:       1'b1,
    voltage_trim_code: 4'h0,
    shared_pin_supply: 1'b0,
    supply_detect_on:  1'b0
  };

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ADDR  = 3'h1,
    ST_ACK_A = 3'h3,
    ST_WR    = 3'h2,
    ST_ACK_W = 3'h6,
    ST_RD    = 3'h7,
    ST_ACK_R = 3'h5
  } i2c_state_t;

endpackage

/* segment_lcd_display_core.sv */
// Display core: serial slave, display memory, frame timing and common/segment drive
`timescale 1ns/1ps

module segment_lcd_display_core
  import lcd_core_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  input  wire logic                    clk_en,
  input  wire logic                    scl_in,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe_n,
  input  wire logic                    cfg_load,
  input  wire lcd_core_pkg::lcd_cfg_t  cfg_in,
  output lcd_core_pkg::lcd_cfg_t       cfg_state,
  output lcd_core_pkg::lvl_t [3:0]     common_drive_outputs,
  output lcd_core_pkg::lvl_t [3:0]     shared_common_segment_outputs,
  output lcd_core_pkg::lvl_t [15:0]    segment_drive_outputs
);
  import lcd_core_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic seg_on(input logic [15:0][7:0] mem, input logic [4:0] k,
                                  input logic [2:0] slot, input logic eighth);
    if (eighth) begin
      seg_on = mem[4'(k - 5'd4)][slot];
    end else begin
      seg_on = mem[k[4:1]][{k[0], slot[1:0]}];
    end
  endfunction

  function automatic lvl_t drive_lvl(input logic pol, input logic sel, input logic is_com,
                                     input lvl_t full);
    lvl_t l;
    if (is_com) begin
      l = sel ? full : LVL_NONSEL;
    end else begin
      l = sel ? LVL_SEG_ON : LVL_SEG_OFF;
    end
    drive_lvl = pol ? lvl_t'(full - l) : l;
  endfunction

  // ****************************************************************
  // Configuration
  // ****************************************************************
  lcd_cfg_t cfg_reg;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_reg <= CFG_RESET;
    end else if (clk_en && cfg_load) begin
      cfg_reg <= cfg_in;
    end
  end

  assign cfg_state = cfg_reg;

  // ****************************************************************
  // Serial slave
  // ****************************************************************
  i2c_state_t       st_reg;
  logic             scl_q;
  logic             sda_q;
  logic [3:0]       bit_cnt;
  logic [7:0]       shift_reg;
  logic [7:0]       tx_reg;
  logic             rw_reg;
  logic             drive_reg;
  logic [3:0]       ptr_reg;
  logic             ptr_pending;
  logic [15:0][7:0] ram_reg;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_c;
  logic             stop_c;
  logic             addr_hit;
  logic             wr_done;
  logic             rd_load;

  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  assign start_c  = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_c   = scl_in & scl_q & ~sda_q & sda_in;
  assign addr_hit = (shift_reg[7:1] == DEV_ADDR);
  assign wr_done  = (st_reg == ST_WR) && scl_fall && (bit_cnt == BITS_BYTE);
  assign rd_load  = scl_fall && (((st_reg == ST_ACK_A) && rw_reg) || (st_reg == ST_ACK_R));

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg    <= ST_IDLE;
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      bit_cnt   <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg    <= 8'h00;
      rw_reg    <= 1'b0;
      drive_reg <= 1'b0;
    end else if (clk_en) begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (start_c) begin
        st_reg    <= ST_ADDR;
        bit_cnt   <= 4'h0;
        drive_reg <= 1'b0;
      end else if (stop_c) begin
        st_reg    <= ST_IDLE;
        drive_reg <= 1'b0;
      end else begin
        unique case (st_reg)
          ST_IDLE: begin
            drive_reg <= 1'b0;
          end
          ST_ADDR, ST_WR: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_in};
              bit_cnt   <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == BITS_BYTE) begin
              if (st_reg == ST_WR) begin
                st_reg    <= ST_ACK_W;
                drive_reg <= 1'b1;
              end else if (addr_hit) begin
                st_reg    <= ST_ACK_A;
                drive_reg <= 1'b1;
                rw_reg    <= shift_reg[0];
              end else begin
                st_reg <= ST_IDLE;
              end
            end
          end
          ST_ACK_A, ST_ACK_R: begin
            if (scl_rise && st_reg == ST_ACK_R && sda_in) begin
              st_reg <= ST_IDLE;
            end else if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (rd_load) begin
                st_reg    <= ST_RD;
                tx_reg    <= ram_reg[ptr_reg];
                drive_reg <= ~ram_reg[ptr_reg][7];
              end else begin
                st_reg    <= ST_WR;
                drive_reg <= 1'b0;
              end
            end
          end
          ST_ACK_W: begin
            if (scl_fall) begin
              st_reg    <= ST_WR;
              bit_cnt   <= 4'h0;
              drive_reg <= 1'b0;
            end
          end
          ST_RD: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == BITS_BYTE) begin
                st_reg    <= ST_ACK_R;
                drive_reg <= 1'b0;
              end else begin
                drive_reg <= ~tx_reg[3'(4'h7 - bit_cnt)];
              end
            end
          end
          default: begin
            st_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Open drain: the pin is only ever pulled low
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~drive_reg;

  // ****************************************************************
  // Pointer and display memory
  // ****************************************************************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_reg     <= 4'h0;
      ptr_pending <= 1'b0;
      ram_reg     <= '0;
    end else if (clk_en) begin
      if (start_c) begin
        ptr_pending <= 1'b1;
      end else if (wr_done && ptr_pending) begin
        ptr_reg     <= shift_reg[3:0];
        ptr_pending <= 1'b0;
      end else if (wr_done) begin
        ram_reg[ptr_reg] <= shift_reg;
        ptr_reg          <= ptr_reg + 4'h1;
      end else if (rd_load) begin
        ptr_reg <= ptr_reg + 4'h1;
      end
    end
  end

  // ****************************************************************
  // Frame timing
  // ****************************************************************
  logic [10:0] div_cnt;
  logic        sys_tick;
  logic [6:0]  slot_cnt;
  logic [6:0]  slot_len;
  logic [2:0]  slot_idx;
  logic        frame_pol;
  logic [15:0] blink_cnt;
  logic        blank;
  logic        disp_active;

  assign sys_tick = cfg_reg.osc_on && (div_cnt == 11'(SYS_DIV - 1));

  always_comb begin
    unique case ({cfg_reg.frame_fast, cfg_reg.duty_eighth})
      2'b00: slot_len = 7'(SLOT_SLOW_4);
      2'b01: slot_len = 7'(SLOT_SLOW_8);
      2'b10: slot_len = 7'(SLOT_FAST_4);
      2'b11: slot_len = 7'(SLOT_FAST_8);
    endcase
  end

  always_comb begin
    unique case (cfg_reg.blink_mode)
      2'h0: blank = 1'b0;
      2'h1: blank = blink_cnt[BLINK_BIT1];
      2'h2: blank = blink_cnt[BLINK_BIT2];
      2'h3: blank = blink_cnt[BLINK_BIT3];
    endcase
  end

  // Stopped oscillator freezes all display timing, which is what saves power
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt   <= 11'h000;
      slot_cnt  <= 7'h00;
      slot_idx  <= 3'h0;
      frame_pol <= 1'b0;
      blink_cnt <= 16'h0000;
    end else if (clk_en && cfg_reg.osc_on) begin
      div_cnt <= sys_tick ? 11'h000 : div_cnt + 11'h001;
      if (sys_tick) begin
        blink_cnt <= blink_cnt + 16'h0001;
        if (slot_cnt >= slot_len - 7'h01) begin
          slot_cnt <= 7'h00;
          if (slot_idx >= (cfg_reg.duty_eighth ? 3'h7 : 3'h3)) begin
            slot_idx  <= 3'h0;
            frame_pol <= ~frame_pol;
          end else begin
            slot_idx <= slot_idx + 3'h1;
          end
        end else begin
          slot_cnt <= slot_cnt + 7'h01;
        end
      end
    end
  end

  // ****************************************************************
  // Common and segment drive
  // ****************************************************************
  lvl_t       full;
  lvl_t [3:0] com_next;
  lvl_t [3:0] shr_next;
  lvl_t [15:0] seg_next;

  assign full        = cfg_reg.bias_quarter ? LVL_FULL_4 : LVL_FULL_3;
  assign disp_active = cfg_reg.osc_on && cfg_reg.bias_on && cfg_reg.display_on && !blank;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      com_next[i] = drive_lvl(frame_pol, slot_idx == 3'(i), 1'b1, full);
      if (cfg_reg.duty_eighth) begin
        shr_next[i] = drive_lvl(frame_pol, slot_idx == 3'(i + 4), 1'b1, full);
      end else begin
        shr_next[i] = drive_lvl(frame_pol, seg_on(ram_reg, 5'(i), slot_idx, 1'b0),
                                1'b0, full);
      end
    end
    for (int k = 0; k < 16; k++) begin
      seg_next[k] = drive_lvl(frame_pol, seg_on(ram_reg, 5'(k + 4), slot_idx,
                              cfg_reg.duty_eighth), 1'b0, full);
    end
    if (!disp_active) begin
      com_next = {4{full}};
      shr_next = {4{full}};
      seg_next = {16{full}};
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      common_drive_outputs          <= {4{LVL_FULL_3}};
      shared_common_segment_outputs <= {4{LVL_FULL_3}};
      segment_drive_outputs         <= {16{LVL_FULL_3}};
    end else if (clk_en) begin
      common_drive_outputs          <= com_next;
      shared_common_segment_outputs <= shr_next;
      segment_drive_outputs         <= seg_next;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  idle_outputs_a: assert property (clk_en && !disp_active |=>
      segment_drive_outputs == {16{$past(full)}} && common_drive_outputs == {4{$past(full)}})
    else $error("outputs not idle while display off");
  addr_ack_a: assert property (clk_en && st_reg == ST_ADDR && scl_fall && bit_cnt == 4'h8
      && addr_hit && !start_c |=> st_reg == ST_ACK_A && !sda_oe_n)
    else $error("matching address not acknowledged");
  addr_nack_a: assert property (clk_en && st_reg == ST_ADDR && scl_fall && bit_cnt == 4'h8
      && !addr_hit |=> st_reg == ST_IDLE && sda_oe_n)
    else $error("foreign address acknowledged");
  ptr_step_a: assert property (clk_en && (rd_load || (wr_done && !ptr_pending))
      |=> ptr_reg == $past(ptr_reg) + 4'h1)
    else $error("pointer did not advance");
  ram_store_a: assert property (clk_en && wr_done && !ptr_pending
      |=> ram_reg[$past(ptr_reg)] == $past(shift_reg))
    else $error("data byte not stored");
  osc_off_a: assert property (!cfg_reg.osc_on |-> !sys_tick ##1 $stable(slot_idx))
    else $error("timing runs with oscillator off");
  tick_period_a: assert property (clk_en && sys_tick |=> div_cnt == 11'h000)
    else $error("tick divider not restarted");
  blink_off_a: assert property (clk_en && cfg_reg.blink_mode == 2'h0 && cfg_reg.osc_on
      && cfg_reg.bias_on && cfg_reg.display_on |=> common_drive_outputs != {4{$past(full)}})
    else $error("blanking with blink off");
  slot_wrap_a: assert property (clk_en && sys_tick && slot_cnt >= slot_len - 7'h01
      && slot_idx == 3'h3 && !cfg_reg.duty_eighth |=> slot_idx == 3'h0 && $changed(frame_pol))
    else $error("frame did not end after four slots");

  addr_hit_c: cover property (st_reg == ST_ACK_A);
  write_c:    cover property (wr_done && !ptr_pending);
  read_c:     cover property (st_reg == ST_ACK_R);
  active_c:   cover property (disp_active && cfg_reg.duty_eighth);

endmodule

/* i2c_host_model.sv */
// Behavioural serial bus master standing in for the host controller
`timescale 1ns/1ps
module i2c_host_model (
  input  wire logic mclk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_rel
);
  // ****************************************************************
  // Bus primitives
  // ****************************************************************
  // Half clock period in mclk cycles; raise it to play a slow host
  int half = 6;

  // Both lines high at power-up; data is released to the pull-up, the clock is driven high
  initial begin
    scl     = 1'b1;
    sda_rel = 1'b1;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Also serves as repeated start: data is released before the clock rises
  task automatic start_cond();
    @(posedge mclk);
    sda_rel <= 1'b1;
    wait_cyc(half);
    scl <= 1'b1;
    wait_cyc(half);
    sda_rel <= 1'b0;
    wait_cyc(half);
    scl <= 1'b0;
    wait_cyc(half);
  endtask

  task automatic stop_cond();
    @(posedge mclk);
    sda_rel <= 1'b0;
    wait_cyc(half);
    scl <= 1'b1;
    wait_cyc(half);
    sda_rel <= 1'b1;
    wait_cyc(half);
  endtask

  // Data changes one cycle after the clock falls, so hold time is never zero
  task automatic bit_cyc(input logic b, output logic r);
    sda_rel <= b;
    wait_cyc(half);
    scl <= 1'b1;
    wait_cyc(half);
    r = sda_line;
    scl <= 1'b0;
    wait_cyc(1);
  endtask

  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ack_in,
                      output logic [7:0] q, output logic ack_out);
    for (int i = 7; i >= 0; i--) bit_cyc(d[i], q[i]);
    bit_cyc(ack_in, ack_out);
  endtask
endmodule

/* tb_segment_lcd_display_core.sv */
// Self-checking bench for the segment LCD display core
`timescale 1ns/1ps
module tb_segment_lcd_display_core;
  import lcd_core_pkg::*;
  // ****************************************************************
  // Stimulus, wiring and instances
  // ****************************************************************
  typedef struct packed {
    lcd_cfg_t cfg;
    lvl_t     full;
  } row_t;
  logic        mclk     = 1'b0;
  logic        sys_rst  = 1'b1;
  logic        clk_en   = 1'b1;
  logic        cfg_load = 1'b0;
  lcd_cfg_t    cfg_in   = CFG_RESET;
  lcd_cfg_t    cfg_state;
  lcd_cfg_t    keep;
  lvl_t [3:0]  common_drive_outputs;
  lvl_t [3:0]  shared_common_segment_outputs;
  lvl_t [15:0] segment_drive_outputs;
  logic        scl;
  logic        sda_rel;
  logic        sda_out;
  logic        sda_oe_n;
  logic        sda_w;
  logic [7:0]  q;
  logic        a;
  logic [7:0]  ram_img [16];
  row_t        rows [4];
  int          n_errors   = 0;
  int          num_checks = 0;
  int          cycles     = 0;
  int          ticks      = 0;

  always #12.5 mclk = ~mclk;
  // Pull-up on the data line; either party may pull it low
  assign sda_w = sda_rel & (sda_oe_n | sda_out);

  segment_lcd_display_core segment_lcd_display_core_inst (
    .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .cfg_load(cfg_load), .cfg_in(cfg_in),
    .cfg_state(cfg_state), .common_drive_outputs(common_drive_outputs),
    .shared_common_segment_outputs(shared_common_segment_outputs),
    .segment_drive_outputs(segment_drive_outputs));
  i2c_host_model i2c_host_model_inst (
    .mclk(mclk), .sda_line(sda_w), .scl(scl), .sda_rel(sda_rel));

  // ****************************************************************
  // Compare and helper tasks
  // ****************************************************************
  task automatic chk_lvl(input lvl_t got, input lvl_t exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask
  task automatic chk_cfg(input lcd_cfg_t got, input lcd_cfg_t exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: config got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_num(input int got, input int exp, input string what);
    num_checks++;
    if (got != exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask
  // Pins 0..3 are commons 0..3, pins 4..7 commons 4..7 at 1/8 duty only; segment s sits at pin s+4 in either mode
  function automatic lvl_t pin(input int i);
    if (i < 4) return common_drive_outputs[i];
    if (i < 8) return shared_common_segment_outputs[i-4];
    return segment_drive_outputs[i-8];
  endfunction
  function automatic lcd_cfg_t mk(input logic [5:0] f, input logic [1:0] bl,
                                  input logic [3:0] tr, input logic [2:0] x);
    return lcd_cfg_t'({f, bl, x[2], tr, x[1:0]});
  endfunction
  task automatic load_cfg(input lcd_cfg_t c);
    @(posedge mclk);
    cfg_in   <= c;
    cfg_load <= 1'b1;
    @(posedge mclk);
    cfg_load <= 1'b0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic all_full(input lvl_t f);
    for (int i = 0; i < 24; i++) chk_lvl(pin(i), f, "idle level");
  endtask
  // Slot and frame polarity are read off the commons, so no slot timing is assumed
  task automatic check_map(input logic eighth, input lvl_t f);
    logic pol;
    int   slot;
    int   ncom;
    lvl_t lv;
    ncom = eighth ? 8 : 4;
    pol  = !(pin(0) === f || pin(0) === 3'h1);
    slot = 0;
    for (int c = 0; c < ncom; c++) if (pin(c) === (pol ? 3'h0 : f)) slot = c;
    for (int c = 0; c < ncom; c++) begin
      lv = (c == slot) ? f : 3'h1;
      chk_lvl(pin(c), pol ? f - lv : lv, "common");
    end
    for (int s = eighth ? 4 : 0; s < 20; s++) begin
      lv = (eighth ? ram_img[s-4][slot] : ram_img[s>>1][(s&1)*4+slot]) ? 3'h0 : 3'h2;
      chk_lvl(pin(s+4), pol ? f - lv : lv, "segment");
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Whole run needs about 45000 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      $display("wrong value at %0t: run timed out", $time);
      wrap_up();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rows[0] = '{mk(6'b110000, 2'h0, 4'h0, 3'b100), 3'h3};
    rows[1] = '{mk(6'b011111, 2'h1, 4'h5, 3'b000), 3'h4};
    rows[2] = '{mk(6'b101010, 2'h2, 4'hA, 3'b111), 3'h4};
    rows[3] = '{mk(6'b000101, 2'h3, 4'hF, 3'b010), 3'h3};
    for (int i = 0; i < 16; i++) ram_img[i] = 8'h5A ^ 8'(i * 19);
    repeat (20) @(posedge mclk);
    chk_cfg(cfg_state, CFG_RESET);
    all_full(3'h3);
    sys_rst <= 1'b0;
    // Slot timing is measured inside the serial quiet time: common 1 takes over after 25 ticks
    load_cfg(mk(6'b111111, 2'h0, 4'h0, 3'b100));
    while (common_drive_outputs[1] !== 3'h4 && ticks < 40000) begin
      @(negedge mclk);
      ticks++;
    end
    // Loading returns 3.5 cycles after the load edge; outputs lag the slot by one register
    chk_num(ticks, SYS_DIV * SLOT_FAST_8 - 2, "slot length");
    repeat (40000 - ticks) @(posedge mclk);
    for (int i = 0; i < 4; i++) begin
      load_cfg(rows[i].cfg);
      chk_cfg(cfg_state, rows[i].cfg);
      all_full(rows[i].full);
    end
    i2c_host_model_inst.start_cond();
    i2c_host_model_inst.xfer({DEV_ADDR, 1'b0}, 1'b1, q, a);
    chk_byte({7'h0, a}, 8'h00, "address ack");
    i2c_host_model_inst.xfer(8'h00, 1'b1, q, a);
    for (int i = 0; i < 16; i++) begin
      i2c_host_model_inst.xfer(ram_img[i], 1'b1, q, a);
      chk_byte({7'h0, a}, 8'h00, "data ack");
    end
    i2c_host_model_inst.stop_cond();
    // A foreign address must neither answer nor write
    i2c_host_model_inst.start_cond();
    i2c_host_model_inst.xfer({DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, q, a);
    chk_byte({7'h0, a}, 8'h01, "foreign ack");
    i2c_host_model_inst.xfer(8'h00, 1'b1, q, a);
    i2c_host_model_inst.xfer(8'hFF, 1'b1, q, a);
    i2c_host_model_inst.stop_cond();
    i2c_host_model_inst.half = 20;
    i2c_host_model_inst.start_cond();
    i2c_host_model_inst.xfer({DEV_ADDR, 1'b0}, 1'b1, q, a);
    i2c_host_model_inst.xfer(8'h0E, 1'b1, q, a);
    i2c_host_model_inst.start_cond();
    i2c_host_model_inst.xfer({DEV_ADDR, 1'b1}, 1'b1, q, a);
    chk_byte({7'h0, a}, 8'h00, "read ack");
    for (int i = 0; i < 3; i++) begin
      i2c_host_model_inst.xfer(8'hFF, i == 2, q, a);
      chk_byte(q, ram_img[(14+i)%16], "read data");
    end
    i2c_host_model_inst.stop_cond();
    load_cfg(mk(6'b111001, 2'h0, 4'h0, 3'b100));
    check_map(1'b0, 3'h3);
    load_cfg(mk(6'b111111, 2'h0, 4'h3, 3'b100));
    check_map(1'b1, 3'h4);
    // Load while the clock enable is low must be ignored
    keep = cfg_state;
    @(posedge mclk);
    clk_en <= 1'b0;
    load_cfg(CFG_RESET);
    chk_cfg(cfg_state, keep);
    @(posedge mclk);
    clk_en  <= 1'b1;
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk_cfg(cfg_state, CFG_RESET);
    all_full(3'h3);
    wrap_up();
  end
endmodule
